// ==== inc/psic_regs.vh ====
/*
 * Register map, field positions and reset values of the PHY status and
 * interrupt control bank.
 * Assumes a 5-bit management register address and 16-bit register data.
 */
`ifndef PSIC_REGS_VH
`define PSIC_REGS_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define PSIC_ADDR_BASIC_STATUS    5'h01
`define PSIC_ADDR_STATUS_SUMMARY  5'h10
`define PSIC_ADDR_INT_CONTROL     5'h11
`define PSIC_ADDR_INT_EVENT       5'h12

// ----------------------------------------------------------------------
// Basic mode status fields
// ----------------------------------------------------------------------
`define PSIC_BMS_ANEG_DONE        5
`define PSIC_BMS_REMOTE_FAULT     4
`define PSIC_BMS_LINK             2
`define PSIC_BMS_JABBER           1

// ----------------------------------------------------------------------
// Status summary fields
// ----------------------------------------------------------------------
`define PSIC_SUM_IRQ_PENDING      7
`define PSIC_SUM_REMOTE_FAULT     6
`define PSIC_SUM_JABBER           5
`define PSIC_SUM_ANEG_DONE        4
`define PSIC_SUM_LOOPBACK         3
`define PSIC_SUM_DUPLEX           2
`define PSIC_SUM_SPEED10          1
`define PSIC_SUM_LINK             0

// ----------------------------------------------------------------------
// Interrupt control fields
// ----------------------------------------------------------------------
`define PSIC_ICR_TEST_INT         2
`define PSIC_ICR_EVENT_INT_EN     1
`define PSIC_ICR_INT_OUT_EN       0
`define PSIC_ICR_USED_BITS        3

// ----------------------------------------------------------------------
// Interrupt event status: event flags in the upper byte, enables below
// ----------------------------------------------------------------------
`define PSIC_EVT_COUNT            8
`define PSIC_EVT_FLAG_LSB         8
`define PSIC_EVT_LINK_QUALITY     7
`define PSIC_EVT_ENERGY           6
`define PSIC_EVT_LINK             5
`define PSIC_EVT_SPEED            4
`define PSIC_EVT_DUPLEX           3
`define PSIC_EVT_ANEG_DONE        2
`define PSIC_EVT_FALSE_CARR_HALF  1
`define PSIC_EVT_RX_ERR_HALF      0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PSIC_RST_WORD             16'h0000
`define PSIC_RST_ICR              3'h0
`define PSIC_RST_EVT              8'h00

`endif

// ==== src/psic_evt_latch.v ====
/*
 * A bank of sticky event flags, one per bit.
 * Assumes set pulses come from logic on the same clock; a set in the
 * cycle of a clear keeps the flag set.
 */
`timescale 1ns/1ps

module psic_evt_latch #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         resetn,
    input  wire [W-1:0] setIn,
    input  wire         clrIn,
    output reg  [W-1:0] flags_r
);

    genvar i;

    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_flag
            always @(posedge clk)
            begin
                if (!resetn)
                    flags_r[i] <= 1'b0;
                else if (setIn[i])
                    flags_r[i] <= 1'b1;
                else if (clrIn)
                    flags_r[i] <= 1'b0;
            end
        end
    endgenerate

endmodule // psic_evt_latch

// ==== src/psic_sync2.v ====
/*
 * Two-flip-flop synchroniser for a level that comes from a pin.
 * Assumes the input level changes slowly compared with clk.
 */
`timescale 1ns/1ps

module psic_sync2 #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         resetn,
    input  wire [W-1:0] asyncIn,
    output reg  [W-1:0] syncOut_r
);

    reg [W-1:0] meta_r;

    // The first stage feeds only the second stage.
    // Both stages reset high, the idle level of a pulled-up pin, so no
    // false low reaches the logic in the cycles after reset.
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            meta_r    <= {W{1'b1}};
            syncOut_r <= {W{1'b1}};
        end
        else
        begin
            meta_r    <= asyncIn;
            syncOut_r <= meta_r;
        end
    end

endmodule // psic_sync2

// ==== src/psic_top.v ====
/*
 * PHY status summary, basic mode status latches, interrupt control and
 * interrupt event status for one port, with the shared power-down or
 * interrupt pin.
 * Assumes status inputs come from PHY logic on clk; the pin input comes
 * from outside and is synchronised. Registers are reached over a plain
 * address, strobe and data port with read data one cycle later.
 */
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "psic_regs.vh"

module psic_top #(
    parameter AW = 5,
    parameter DW = 16
) (
    input  wire          clk,
    input  wire          resetn,
    input  wire [AW-1:0] regAddr,
    input  wire [DW-1:0] regWdata,
    input  wire          regWr,
    input  wire          regRd,
    output reg  [DW-1:0] regRdata_r,
    input  wire          linkUp,
    input  wire          jabberDet,
    input  wire          partnerRemoteFault,
    input  wire          negotiationDone,
    input  wire          loopbackOn,
    input  wire          fullDuplex,
    input  wire          speed10,
    input  wire          energyDet,
    input  wire          linkQualityEvt,
    input  wire          falseCarrierHalf,
    input  wire          rxErrHalf,
    input  wire          pdIrqPinIn,
    output reg           pdIrqPinOut_r,
    output reg           pdIrqPinOeN_r,
    output reg           powerDownReq_r,
    output reg           irqPending_r
);

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    wire pdPinSync;

    psic_sync2 #(
        .W         (1)
    ) u_pin_sync (
        .clk       (clk),
        .resetn    (resetn),
        .asyncIn   (pdIrqPinIn),
        .syncOut_r (pdPinSync)
    );

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    wire rdBasic   = regRd && (regAddr == `PSIC_ADDR_BASIC_STATUS);
    wire rdSummary = regRd && (regAddr == `PSIC_ADDR_STATUS_SUMMARY);
    wire rdIcr     = regRd && (regAddr == `PSIC_ADDR_INT_CONTROL);
    wire rdEvt     = regRd && (regAddr == `PSIC_ADDR_INT_EVENT);
    wire wrIcr     = regWr && (regAddr == `PSIC_ADDR_INT_CONTROL);
    wire wrEvt     = regWr && (regAddr == `PSIC_ADDR_INT_EVENT);

    // ------------------------------------------------------------------
    // Previous values for change detection
    // ------------------------------------------------------------------
    reg linkPrev_r;
    reg speedPrev_r;
    reg duplexPrev_r;
    reg energyPrev_r;
    reg anegPrev_r;
    reg lqPrev_r;
    reg fcHalfPrev_r;
    reg rxHalfPrev_r;

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            linkPrev_r   <= 1'b0;
            speedPrev_r  <= 1'b0;
            duplexPrev_r <= 1'b0;
            energyPrev_r <= 1'b0;
            anegPrev_r   <= 1'b0;
            lqPrev_r     <= 1'b0;
            fcHalfPrev_r <= 1'b0;
            rxHalfPrev_r <= 1'b0;
        end
        else
        begin
            linkPrev_r   <= linkUp;
            speedPrev_r  <= speed10;
            duplexPrev_r <= fullDuplex;
            energyPrev_r <= energyDet;
            anegPrev_r   <= negotiationDone;
            lqPrev_r     <= linkQualityEvt;
            fcHalfPrev_r <= falseCarrierHalf;
            rxHalfPrev_r <= rxErrHalf;
        end
    end

    // ------------------------------------------------------------------
    // Basic mode status latches
    // ------------------------------------------------------------------
    // Remote fault and jabber latch high, link latches low; a condition
    // present in the cycle of the clearing read keeps the latch.
    reg remoteFault_r;
    reg jabber_r;
    reg linkLatched_r;

    wire jabberSeen = jabberDet && speed10;

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            remoteFault_r <= 1'b0;
            jabber_r      <= 1'b0;
            linkLatched_r <= 1'b0;
        end
        else
        begin
            if (partnerRemoteFault)
                remoteFault_r <= 1'b1;
            else if (rdBasic)
                remoteFault_r <= 1'b0;
            if (jabberSeen)
                jabber_r <= 1'b1;
            else if (rdBasic)
                jabber_r <= 1'b0;
            if (!linkUp)
                linkLatched_r <= 1'b0;
            else if (rdBasic)
                linkLatched_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt control register
    // ------------------------------------------------------------------
    reg [`PSIC_ICR_USED_BITS-1:0] icr_r;

    always @(posedge clk)
    begin
        if (!resetn)
            icr_r <= `PSIC_RST_ICR;
        else if (wrIcr)
            icr_r <= regWdata[`PSIC_ICR_USED_BITS-1:0];
    end

    wire testInt  = icr_r[`PSIC_ICR_TEST_INT];
    wire eventEn  = icr_r[`PSIC_ICR_EVENT_INT_EN];
    wire intOutEn = icr_r[`PSIC_ICR_INT_OUT_EN];

    // ------------------------------------------------------------------
    // Interrupt event flags and enables
    // ------------------------------------------------------------------
    reg  [`PSIC_EVT_COUNT-1:0] evtSet;
    wire [`PSIC_EVT_COUNT-1:0] evtFlags;
    reg  [`PSIC_EVT_COUNT-1:0] evtEn_r;

    always @*
    begin
        evtSet = `PSIC_RST_EVT;
        evtSet[`PSIC_EVT_LINK_QUALITY]    = linkQualityEvt && !lqPrev_r;
        evtSet[`PSIC_EVT_ENERGY]          = energyDet ^ energyPrev_r;
        evtSet[`PSIC_EVT_LINK]            = linkUp ^ linkPrev_r;
        evtSet[`PSIC_EVT_SPEED]           = speed10 ^ speedPrev_r;
        evtSet[`PSIC_EVT_DUPLEX]          = fullDuplex ^ duplexPrev_r;
        evtSet[`PSIC_EVT_ANEG_DONE]       = negotiationDone && !anegPrev_r;
        evtSet[`PSIC_EVT_FALSE_CARR_HALF] = falseCarrierHalf && !fcHalfPrev_r;
        evtSet[`PSIC_EVT_RX_ERR_HALF]     = rxErrHalf && !rxHalfPrev_r;
    end

    // Flags latch regardless of enables, so software can poll them.
    psic_evt_latch #(
        .W       (`PSIC_EVT_COUNT)
    ) u_evt_latch (
        .clk     (clk),
        .resetn  (resetn),
        .setIn   (evtSet),
        .clrIn   (rdEvt),
        .flags_r (evtFlags)
    );

    always @(posedge clk)
    begin
        if (!resetn)
            evtEn_r <= `PSIC_RST_EVT;
        else if (wrEvt)
            evtEn_r <= regWdata[`PSIC_EVT_COUNT-1:0];
    end

    // ------------------------------------------------------------------
    // Interrupt request and shared pin
    // ------------------------------------------------------------------
    // The request uses the flags as they stand; a read of the event
    // register drops it one cycle later unless the test bit or an enabled event set in the read cycle holds it.
    wire eventIrq = eventEn && |(evtFlags & evtEn_r);
    wire irqReq   = testInt || eventIrq;

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            irqPending_r   <= 1'b0;
            pdIrqPinOut_r  <= 1'b1;
            pdIrqPinOeN_r  <= 1'b1;
            powerDownReq_r <= 1'b0;
        end
        else
        begin
            irqPending_r   <= irqReq;
            pdIrqPinOut_r  <= !irqReq;
            pdIrqPinOeN_r  <= !intOutEn;
            powerDownReq_r <= !intOutEn && !pdPinSync;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    reg [DW-1:0] rdNxt;

    always @*
    begin
        rdNxt = `PSIC_RST_WORD;
        if (rdBasic)
        begin
            rdNxt[`PSIC_BMS_ANEG_DONE]    = negotiationDone;
            rdNxt[`PSIC_BMS_REMOTE_FAULT] = remoteFault_r;
            rdNxt[`PSIC_BMS_LINK]         = linkLatched_r;
            rdNxt[`PSIC_BMS_JABBER]       = jabber_r;
        end
        else if (rdSummary)
        begin
            rdNxt[`PSIC_SUM_IRQ_PENDING]  = irqPending_r;
            rdNxt[`PSIC_SUM_REMOTE_FAULT] = remoteFault_r;
            rdNxt[`PSIC_SUM_JABBER]       = jabber_r;
            rdNxt[`PSIC_SUM_ANEG_DONE]    = negotiationDone;
            rdNxt[`PSIC_SUM_LOOPBACK]     = loopbackOn;
            rdNxt[`PSIC_SUM_DUPLEX]       = fullDuplex;
            rdNxt[`PSIC_SUM_SPEED10]      = speed10;
            rdNxt[`PSIC_SUM_LINK]         = linkLatched_r;
        end
        else if (rdIcr)
        begin
            rdNxt[`PSIC_ICR_USED_BITS-1:0] = icr_r;
        end
        else if (rdEvt)
        begin
            rdNxt[`PSIC_EVT_FLAG_LSB+`PSIC_EVT_COUNT-1:`PSIC_EVT_FLAG_LSB]
                = evtFlags;
            rdNxt[`PSIC_EVT_COUNT-1:0] = evtEn_r;
        end
    end

    always @(posedge clk)
    begin
        if (!resetn)
            regRdata_r <= `PSIC_RST_WORD;
        else
            regRdata_r <= rdNxt;
    end

endmodule // psic_top

// ==== testbench/psic_mgmt.sv ====
/* Management controller model driving the register port.
   Assumes read data stands only in the cycle after the read strobe. */
`timescale 1ns/1ps

module psic_mgmt (
    input  wire        clk,
    output reg  [4:0]  regAddr,
    output reg  [15:0] regWdata,
    output reg         regWr,
    output reg         regRd,
    input  wire [15:0] regRdata_r
);
    // ---------------------------------------------------------------
    // Bus cycles
    // ---------------------------------------------------------------
    initial
    begin
        {regAddr, regWdata, regWr, regRd} = 23'h000000;
    end
    task wr(input [4:0] a, input [15:0] v);
    begin
        @(posedge clk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        regWdata <= ~v;
    end
    endtask
    task rd(input [4:0] a, output [15:0] v);
    begin
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        v = regRdata_r;
    end
    endtask
endmodule // psic_mgmt

// ==== testbench/psic_props.sv ====
/* Port checker for the status and interrupt control bank.
   Assumes it is bound to psic_top and sees only its ports. */
`timescale 1ns/1ps

module psic_props #(
    parameter AW = 5,
    parameter DW = 16
) (
    input wire          clk,
    input wire          resetn,
    input wire [AW-1:0] regAddr,
    input wire [DW-1:0] regWdata,
    input wire          regWr,
    input wire          regRd,
    input wire [DW-1:0] regRdata_r,
    input wire          linkUp,
    input wire          jabberDet,
    input wire          partnerRemoteFault,
    input wire          negotiationDone,
    input wire          loopbackOn,
    input wire          fullDuplex,
    input wire          speed10,
    input wire          energyDet,
    input wire          linkQualityEvt,
    input wire          falseCarrierHalf,
    input wire          rxErrHalf,
    input wire          pdIrqPinIn,
    input wire          pdIrqPinOut_r,
    input wire          pdIrqPinOeN_r,
    input wire          powerDownReq_r,
    input wire          irqPending_r
);
    // ---------------------------------------------------------------
    // Shadow of the control bits, rebuilt from the write strobes
    // ---------------------------------------------------------------
    reg [2:0] icrSh_r;
    always @(posedge clk)
    begin
        if (!resetn)
            icrSh_r <= 3'h0;
        else if (regWr && regAddr == 5'h11)
            icrSh_r <= regWdata[2:0];
    end

    default clocking dcb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_rdata_idle: assert property (!$past(regRd) |-> regRdata_r == 16'h0000)
        else $error("read data not zero outside a read answer");
    chk_ctrl_readback: assert property (
        regRd && regAddr == 5'h11 |=> regRdata_r == {13'h0000, $past(icrSh_r)})
        else $error("control readback differs from written bits");
    chk_status_live: assert property (
        regRd && regAddr == 5'h10 &&
        $stable({negotiationDone, loopbackOn, fullDuplex, speed10})
        |=> regRdata_r[4:1] == {$past(negotiationDone), $past(loopbackOn),
            $past(fullDuplex), $past(speed10)})
        else $error("summary status bits differ from inputs");
    chk_test_holds: assert property (
        icrSh_r[2] && $past(icrSh_r[2]) |-> irqPending_r)
        else $error("test interrupt not held");
    chk_event_gated: assert property (
        icrSh_r[2:1] == 2'b00 && $past(icrSh_r[2:1]) == 2'b00
        |-> !irqPending_r)
        else $error("interrupt without test or global enable");
    chk_pin_follows: assert property (
        !pdIrqPinOeN_r |-> pdIrqPinOut_r == !irqPending_r)
        else $error("pin drive does not follow interrupt");
    chk_oe_setting: assert property (
        regWr && regAddr == 5'h11
        |-> ##2 pdIrqPinOeN_r == !$past(regWdata[0], 2))
        else $error("pin enable does not follow control bit");
    chk_pd_blocked: assert property (
        !pdIrqPinOeN_r && !$past(pdIrqPinOeN_r, 2) |-> !powerDownReq_r)
        else $error("power-down request while pin is an output");
    chk_pd_from_pin: assert property (
        powerDownReq_r == (pdIrqPinOeN_r && !$past(pdIrqPinIn, 3)))
        else $error("power-down request does not follow the pin");
endmodule // psic_props

// ==== testbench/tb_top.sv ====
/* Self-checking bench for psic_top with the management model.
   Assumes the register port answers reads one cycle later. */
`timescale 1ns/1ps

module tb_top;
    reg         clk = 1'b0;
    reg         resetn = 1'b0;
    wire [4:0]  regAddr;
    wire [15:0] regWdata, regRdata_r;
    wire        regWr, regRd, pdIrqPinIn, pdIrqPinOut_r, pdIrqPinOeN_r;
    wire        powerDownReq_r, irqPending_r;
    reg         linkUp, jabberDet, partnerRemoteFault, negotiationDone;
    reg         loopbackOn, fullDuplex, speed10, energyDet, linkQualityEvt;
    reg         falseCarrierHalf, rxErrHalf, pdExt, lb, dup;
    reg  [15:0] d;
    integer     failures = 0, totalChecks = 0, i;

    // ---------------------------------------------------------------
    // Harness
    // ---------------------------------------------------------------
    always #2 clk = ~clk;
    // An undriven pin takes the external level pdExt unless the block drives it.
    assign pdIrqPinIn = pdIrqPinOeN_r ? pdExt : pdIrqPinOut_r;

    psic_mgmt mgmt (.clk(clk), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata_r(regRdata_r));
    psic_top uut (.clk(clk), .resetn(resetn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata_r(regRdata_r), .linkUp(linkUp), .jabberDet(jabberDet),
        .partnerRemoteFault(partnerRemoteFault),
        .negotiationDone(negotiationDone), .loopbackOn(loopbackOn),
        .fullDuplex(fullDuplex), .speed10(speed10), .energyDet(energyDet),
        .linkQualityEvt(linkQualityEvt), .falseCarrierHalf(falseCarrierHalf),
        .rxErrHalf(rxErrHalf), .pdIrqPinIn(pdIrqPinIn),
        .pdIrqPinOut_r(pdIrqPinOut_r), .pdIrqPinOeN_r(pdIrqPinOeN_r),
        .powerDownReq_r(powerDownReq_r), .irqPending_r(irqPending_r));

    task chk(input [15:0] got, input [15:0] exp);
    begin
        totalChecks = totalChecks + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task rdc(input [4:0] a, input [15:0] e);
    begin
        mgmt.rd(a, d);
        chk(d, e);
    end
    endtask
    task wt(input integer n);
    begin
        repeat (n) @(posedge clk);
        #1;
    end
    endtask
    task print_verdict;
    begin
        if (failures == 0 && totalChecks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask

    initial
    begin
        #20000;
        failures = failures + 1;
        print_verdict;
    end

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    initial
    begin
        {linkUp, jabberDet, partnerRemoteFault, negotiationDone} = 4'h0;
        {loopbackOn, fullDuplex, speed10, energyDet} = 4'h0;
        {linkQualityEvt, falseCarrierHalf, rxErrHalf} = 3'h0;
        pdExt = 1'b1;
        d = $urandom(32'h7FCC1FD7);
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        wt(2);
        chk({13'h0000, powerDownReq_r, pdIrqPinOeN_r, pdIrqPinOut_r},
            16'h0003);
        rdc(5'h11, 16'h0000);
        rdc(5'h12, 16'h0000);
        rdc(5'h10, 16'h0000);
        d = $urandom;
        lb = d[0];
        dup = d[1];
        @(posedge clk) {linkUp, negotiationDone, jabberDet} <= 3'h7;
        {loopbackOn, fullDuplex} <= {lb, dup};
        wt(3);
        @(posedge clk) jabberDet <= 1'b0;
        mgmt.rd(5'h01, d);
        rdc(5'h10, {9'h000, 3'b001, lb, dup, 2'b01});
        @(posedge clk) {speed10, jabberDet, partnerRemoteFault} <= 3'h7;
        wt(2);
        @(posedge clk) {jabberDet, partnerRemoteFault} <= 2'b00;
        wt(2);
        for (i = 0; i < 2; i = i + 1)
            rdc(5'h10, {9'h000, 3'b111, lb, dup, 2'b11});
        mgmt.rd(5'h01, d);
        rdc(5'h10, {9'h000, 3'b001, lb, dup, 2'b11});
        for (i = 0; i < 8; i = i + 1)
        begin
            d = $urandom;
            mgmt.wr(5'h11, {d[15:3], i[2:0]});
            rdc(5'h11, {13'h0000, i[2:0]});
        end
        mgmt.wr(5'h11, 16'h0000);
        @(posedge clk) {linkQualityEvt, negotiationDone} <= 2'b00;
        wt(3);
        mgmt.rd(5'h12, d);
        @(posedge clk) {linkQualityEvt, energyDet, linkUp, speed10, fullDuplex,
            negotiationDone, falseCarrierHalf, rxErrHalf} <= ~{linkQualityEvt,
            energyDet, linkUp, speed10, fullDuplex, negotiationDone,
            falseCarrierHalf, rxErrHalf};
        wt(3);
        chk({15'h0000, irqPending_r}, 16'h0000);
        rdc(5'h12, 16'hFF00);
        rdc(5'h12, 16'h0000);
        mgmt.wr(5'h12, 16'h0020);
        mgmt.wr(5'h11, 16'h0003);
        @(posedge clk) energyDet <= ~energyDet;
        wt(4);
        chk({15'h0000, irqPending_r}, 16'h0000);
        @(posedge clk) linkUp <= ~linkUp;
        wt(4);
        chk({14'h0000, pdIrqPinOut_r, irqPending_r}, 16'h0001);
        rdc(5'h12, 16'h6020);
        wt(3);
        chk({15'h0000, irqPending_r}, 16'h0000);
        mgmt.wr(5'h11, 16'h0004);
        wt(3);
        chk({14'h0000, pdIrqPinOeN_r, irqPending_r}, 16'h0003);
        mgmt.wr(5'h11, 16'h0000);
        wt(3);
        chk({15'h0000, irqPending_r}, 16'h0000);
        @(posedge clk) pdExt <= 1'b0;
        wt(5);
        chk({15'h0000, powerDownReq_r}, 16'h0001);
        mgmt.wr(5'h11, 16'h0001);
        wt(5);
        chk({14'h0000, pdIrqPinOeN_r, powerDownReq_r}, 16'h0000);
        print_verdict;
    end
endmodule // tb_top

bind psic_top psic_props #(.AW(AW), .DW(DW)) u_props (.clk(clk),
    .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata_r(regRdata_r), .linkUp(linkUp),
    .jabberDet(jabberDet), .partnerRemoteFault(partnerRemoteFault),
    .negotiationDone(negotiationDone), .loopbackOn(loopbackOn),
    .fullDuplex(fullDuplex), .speed10(speed10), .energyDet(energyDet),
    .linkQualityEvt(linkQualityEvt), .falseCarrierHalf(falseCarrierHalf),
    .rxErrHalf(rxErrHalf), .pdIrqPinIn(pdIrqPinIn),
    .pdIrqPinOut_r(pdIrqPinOut_r), .pdIrqPinOeN_r(pdIrqPinOeN_r),
    .powerDownReq_r(powerDownReq_r), .irqPending_r(irqPending_r));
